// >>> rtl/gtm_timer.sv
// gated 16-bit up-counter with clock source, prescale, gate logic and interrupts
// Contract
// - clock source field picks lf osc, pin rising edge, system clock or clock/4.
// - prescale field divides selected edges by 8, 4, 2 or 1.
// - sync bit clear synchronises the async clock input; set bypasses it. Here set skips only the level filter; the pin still passes three flops.
// - timer-on enables counting; clearing it stops and clears gate flip-flop.
// - gate enable ignored while off; on, one makes count follow gate.
// - gate polarity set counts while gate high, clear while gate low.
// - toggle bit routes gate through toggle flop; clear holds it cleared.
// - toggle flop changes on every rising edge of the selected gate.
// - single-pulse bit enables single-pulse acquisition controlling the gate.
// - software sets acquire status to arm; hardware clears it when done.
// - gate level status shows current gate, independent of gate enable.
// - gate source: 00 pin, 01 byte timer overflow, 10 comparator, 11 reserved.
// - control bits 3 and 1 read zero and ignore writes.
// - writable control fields clear to zero on reset.
// - 16-bit count rolls from ffff to 0000 and sets overflow flag.
// - single-pulse clears status on trailing gate edge, no counts until rearmed.
// - falling edge of gate level sets gate event flag, even if gate disabled.
module gtm_timer #(
	parameter int CNT_W = 16
) (
	input  wire logic             clk,
	input  wire logic             arst_n,
	input  wire gtm_pkg::gtm_bus_t bus,
	output logic [7:0]            rdata,
	input  wire gtm_pkg::gtm_src_t src,
	output logic                  irq
);
	logic [7:0]       ctrl;
	logic [7:0]       gctl;
	logic [CNT_W-1:0] count;
	logic [7:0]       irqSt;
	logic [7:0]       irqMsk;
	logic [2:0]       pinClkSync;
	logic [2:0]       oscSync;
	logic [2:0]       gpinSync;
	logic [2:0]       cmpSyncFf;
	logic             pinClkLvl;
	logic             oscLvl;
	logic             gpinLvl;
	logic             cmpLvl;
	logic             pinClkPrev;
	logic             oscPrev;
	logic [1:0]       instrDiv;
	logic             srcTick;
	logic [2:0]       preCnt;
	logic             cntTick;
	logic             gateSel;
	logic             gateSelPrev;
	logic             toggleFf;
	logic             gateLvl;
	logic             gateVal;
	logic             gateValPrev;
	logic             gateOpen;
	logic             countEn;
	logic             armed;
	logic             wrCtrl;
	logic             wrGate;
	logic             wrLo;
	logic             wrHi;
	logic             wrSt;
	logic             ovfEvt;
	logic             gateEvt;
	logic             trailEdge;
	logic [1:0]       psSel;
	logic [2:0]       psMax;

	assign wrCtrl = bus.wr && bus.addr == gtm_pkg::ADDR_CTRL;
	assign wrGate = bus.wr && bus.addr == gtm_pkg::ADDR_GATE;
	assign wrLo   = bus.wr && bus.addr == gtm_pkg::ADDR_CNT_LO;
	assign wrHi   = bus.wr && bus.addr == gtm_pkg::ADDR_CNT_HI;
	assign wrSt   = bus.wr && bus.addr == gtm_pkg::ADDR_IRQ_ST;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			ctrl <= gtm_pkg::RESET_BYTE;
		else if (wrCtrl)
			ctrl <= bus.wdata & gtm_pkg::CTRL_WMASK;
	end

	// gate control: bits 7..4 and 1..0 stored; go bit handled apart, value bit live
	// cleared at reset
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			gctl <= gtm_pkg::RESET_BYTE;
		end
		else if (wrGate)
		begin
			gctl <= bus.wdata & 8'hf3;
		end
	end

	// three-stage synchronisers on pin and foreign-clock inputs
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pinClkSync <= 3'h0;
			oscSync    <= 3'h0;
			gpinSync   <= 3'h0;
			cmpSyncFf  <= 3'h0;
		end
		else
		begin
			pinClkSync <= {pinClkSync[1:0], src.extClkPin};
			oscSync    <= {oscSync[1:0], src.lowFreqOsc};
			gpinSync   <= {gpinSync[1:0], src.gatePin};
			cmpSyncFf  <= {cmpSyncFf[1:0], src.cmpSync};
		end
	end

	// level held until stages two and three agree
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pinClkLvl <= 1'b0;
			oscLvl    <= 1'b0;
			gpinLvl   <= 1'b0;
			cmpLvl    <= 1'b0;
		end
		else
		begin
			if (pinClkSync[1] == pinClkSync[2])
				pinClkLvl <= pinClkSync[2];
			if (oscSync[1] == oscSync[2])
				oscLvl <= oscSync[2];
			if (gpinSync[1] == gpinSync[2])
				gpinLvl <= gpinSync[2];
			if (cmpSyncFf[1] == cmpSyncFf[2])
				cmpLvl <= cmpSyncFf[2];
		end
	end

	// bypass path
	// single-clock design: bypass drops the filter stage, taking raw pin after three flops
	// trades glitch immunity for one cycle less latency
	logic pinClkUse;
	assign pinClkUse = ctrl[gtm_pkg::CTRL_SYNC_BIT] ? pinClkSync[2] : pinClkLvl;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pinClkPrev <= 1'b0;
			oscPrev    <= 1'b0;
			instrDiv   <= 2'h0;
		end
		else
		begin
			pinClkPrev <= pinClkUse;
			oscPrev    <= oscLvl;
			instrDiv   <= instrDiv + 2'h1;
		end
	end

	always_comb
	begin
		case (ctrl[gtm_pkg::CTRL_CS_LSB +: 2])
			gtm_pkg::CS_INSTR: srcTick = instrDiv == 2'(gtm_pkg::INSTR_DIV - 1);
			gtm_pkg::CS_SYS:   srcTick = 1'b1;
			gtm_pkg::CS_PIN:   srcTick = pinClkUse && !pinClkPrev;
			gtm_pkg::CS_LFOSC: srcTick = oscLvl && !oscPrev;
			default:           srcTick = 1'b0;
		endcase
	end

	assign psSel   = ctrl[gtm_pkg::CTRL_PS_LSB +: 2];
	assign psMax   = 3'((1 << psSel) - 1);
	assign cntTick = srcTick && preCnt == psMax;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			preCnt <= 3'h0;
		else if (wrCtrl || !ctrl[gtm_pkg::CTRL_ON_BIT])
			preCnt <= 3'h0;
		else if (srcTick)
			preCnt <= cntTick ? 3'h0 : preCnt + 3'h1;
	end

	always_comb
	begin
		case (gctl[gtm_pkg::GATE_SS_LSB +: 2])
			gtm_pkg::GS_PIN: gateSel = gpinLvl;
			gtm_pkg::GS_OVF: gateSel = src.byteTimerOvf;
			gtm_pkg::GS_CMP: gateSel = cmpLvl;
			default:         gateSel = !gctl[gtm_pkg::GATE_POL_BIT];
		endcase
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			gateSelPrev <= 1'b0;
		else
			gateSelPrev <= gateSel;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			toggleFf <= 1'b0;
		else if (!ctrl[gtm_pkg::CTRL_ON_BIT] || !gctl[gtm_pkg::GATE_TM_BIT])
			toggleFf <= 1'b0;
		else if (gateSel && !gateSelPrev)
			toggleFf <= !toggleFf;
	end

	// polarity applied
	// toggle output is polarity-neutral, so the invert follows the mux
	assign gateLvl = (gctl[gtm_pkg::GATE_TM_BIT] ? toggleFf : gateSel) ^ !gctl[gtm_pkg::GATE_POL_BIT];

	assign gateVal = gctl[gtm_pkg::GATE_SPM_BIT] ? (gateLvl && armed) : gateLvl;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			gateValPrev <= 1'b0;
		else
			gateValPrev <= gateVal;
	end
	assign trailEdge = gateValPrev && !gateVal;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			armed <= 1'b0;
		else if (wrGate && bus.wdata[gtm_pkg::GATE_GO_BIT] && bus.wdata[gtm_pkg::GATE_SPM_BIT])
			armed <= 1'b1;
		else if (!gctl[gtm_pkg::GATE_SPM_BIT] || trailEdge)
			armed <= 1'b0;
	end

	assign gateOpen = !gctl[gtm_pkg::GATE_EN_BIT] || gateVal;
	assign countEn  = ctrl[gtm_pkg::CTRL_ON_BIT] && gateOpen && cntTick;

	// count and roll over
	// software write wins over an increment in the same cycle
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			count <= '0;
		else if (wrLo)
			count[7:0] <= bus.wdata;
		else if (wrHi)
			count[CNT_W-1:8] <= bus.wdata[CNT_W-9:0];
		else if (countEn)
			count <= count + CNT_W'(1);
	end
	// a count write in the same cycle cancels the rollover
	assign ovfEvt = countEn && &count && !wrLo && !wrHi;

	assign gateEvt = trailEdge;

	// sticky flags, set wins over write-one-to-clear
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			irqSt <= 8'h00;
		else
		begin
			irqSt[7:2] <= 6'h00;
			irqSt[gtm_pkg::IRQ_OVF_BIT]  <= ovfEvt || (irqSt[gtm_pkg::IRQ_OVF_BIT] &&
				!(wrSt && bus.wdata[gtm_pkg::IRQ_OVF_BIT]));
			irqSt[gtm_pkg::IRQ_GATE_BIT] <= gateEvt || (irqSt[gtm_pkg::IRQ_GATE_BIT] &&
				!(wrSt && bus.wdata[gtm_pkg::IRQ_GATE_BIT]));
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			irqMsk <= 8'h00;
		else if (bus.wr && bus.addr == gtm_pkg::ADDR_IRQ_MSK)
			irqMsk <= bus.wdata & 8'h03;
	end

	assign irq = |(irqSt & irqMsk);

	// read port, data one cycle after strobe
	// unimplemented bits zero
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			rdata <= 8'h00;
		else if (bus.rd)
		begin
			case (bus.addr)
				gtm_pkg::ADDR_CTRL:    rdata <= ctrl;
				gtm_pkg::ADDR_GATE:    rdata <= gctl | {4'h0, armed, gateVal, 2'h0};
				gtm_pkg::ADDR_CNT_LO:  rdata <= count[7:0];
				gtm_pkg::ADDR_CNT_HI:  rdata <= count[CNT_W-1:8];
				gtm_pkg::ADDR_IRQ_ST:  rdata <= irqSt;
				gtm_pkg::ADDR_IRQ_MSK: rdata <= irqMsk;
				default:               rdata <= 8'h00;
			endcase
		end
		else
			rdata <= 8'h00;
	end

	overflow_sets_a: assert property (@(posedge clk) disable iff (!arst_n)
		ovfEvt |=> irqSt[gtm_pkg::IRQ_OVF_BIT] && count == '0)
		else $error("overflow flag not set on rollover");
	off_noncount_a: assert property (@(posedge clk) disable iff (!arst_n)
		!ctrl[gtm_pkg::CTRL_ON_BIT] && !wrLo && !wrHi |=> $stable(count))
		else $error("count moved while timer off");
	toggle_held_a: assert property (@(posedge clk) disable iff (!arst_n)
		!gctl[gtm_pkg::GATE_TM_BIT] |=> !toggleFf)
		else $error("toggle flop not held clear");
	toggle_flip_a: assert property (@(posedge clk) disable iff (!arst_n)
		ctrl[gtm_pkg::CTRL_ON_BIT] && gctl[gtm_pkg::GATE_TM_BIT] && gateSel && !gateSelPrev
		&& !wrCtrl && !wrGate |=> toggleFf != $past(toggleFf))
		else $error("toggle flop missed rising edge");
	gate_event_a: assert property (@(posedge clk) disable iff (!arst_n)
		$fell(gateVal) |=> irqSt[gtm_pkg::IRQ_GATE_BIT])
		else $error("gate event flag not set");
	pulse_done_a: assert property (@(posedge clk) disable iff (!arst_n)
		armed && trailEdge && !wrGate |=> !armed)
		else $error("acquire status not cleared");
	reserved_bits_a: assert property (@(posedge clk) disable iff (!arst_n)
		ctrl[3] == 1'b0 && ctrl[1] == 1'b0)
		else $error("unimplemented bits set");
	sys_count_a: assert property (@(posedge clk) disable iff (!arst_n)
		ctrl == 8'h41 && !gctl[gtm_pkg::GATE_EN_BIT] && !bus.wr ##1 !bus.wr
		|=> count == $past(count, 2) + CNT_W'(2))
		else $error("system clock source did not count each cycle");
	gate_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
		ctrl[gtm_pkg::CTRL_ON_BIT] && gctl[gtm_pkg::GATE_EN_BIT] && !gateVal && !wrLo && !wrHi |=> $stable(count))
		else $error("count moved while gate closed");
	reserved_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
		gctl[gtm_pkg::GATE_SS_LSB +: 2] == 2'h3 && !gctl[gtm_pkg::GATE_TM_BIT] |-> !gateVal)
		else $error("reserved gate source not inactive");
	pulse_block_a: assert property (@(posedge clk) disable iff (!arst_n)
		ctrl[gtm_pkg::CTRL_ON_BIT] && gctl[gtm_pkg::GATE_EN_BIT] && gctl[gtm_pkg::GATE_SPM_BIT] && !armed
		&& !wrGate && !wrLo && !wrHi |=> $stable(count))
		else $error("count moved after acquisition ended");
	ovf_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
		wrSt && bus.wdata[gtm_pkg::IRQ_OVF_BIT] && !ovfEvt |=> !irqSt[gtm_pkg::IRQ_OVF_BIT])
		else $error("overflow flag not cleared by write");
	count_load_a: assert property (@(posedge clk) disable iff (!arst_n)
		wrLo |=> count[7:0] == $past(bus.wdata))
		else $error("low count byte not loaded");
	gate_level_a: assert property (@(posedge clk) disable iff (!arst_n)
		!gctl[gtm_pkg::GATE_SPM_BIT] && !gctl[gtm_pkg::GATE_TM_BIT] && gctl[gtm_pkg::GATE_SS_LSB +: 2] == gtm_pkg::GS_OVF
		|-> gateVal == (src.byteTimerOvf == gctl[gtm_pkg::GATE_POL_BIT]))
		else $error("gate value does not follow selected source");
	rollover_c: cover property (@(posedge clk) disable iff (!arst_n) ovfEvt);
	gate_event_c: cover property (@(posedge clk) disable iff (!arst_n) gateEvt);
	pulse_c:    cover property (@(posedge clk) disable iff (!arst_n) armed ##[1:50] !armed);
	toggle_c:   cover property (@(posedge clk) disable iff (!arst_n) toggleFf ##[1:50] !toggleFf);
endmodule

// >>> rtl/gtm_pkg.sv
// shared constants and types for the gated 16-bit timer control block
package gtm_pkg;
	// register indices (plain port, byte wide registers)
	localparam logic [2:0] ADDR_CTRL    = 3'h0;
	localparam logic [2:0] ADDR_GATE    = 3'h1;
	localparam logic [2:0] ADDR_CNT_LO  = 3'h2;
	localparam logic [2:0] ADDR_CNT_HI  = 3'h3;
	localparam logic [2:0] ADDR_IRQ_ST  = 3'h4;
	localparam logic [2:0] ADDR_IRQ_MSK = 3'h5;
	// control register fields
	localparam int CTRL_CS_LSB   = 6;
	localparam int CTRL_PS_LSB   = 4;
	localparam int CTRL_SYNC_BIT = 2;
	localparam int CTRL_ON_BIT   = 0;
	localparam logic [7:0] CTRL_WMASK = 8'hf5;
	// gate control register fields
	localparam int GATE_EN_BIT   = 7;
	localparam int GATE_POL_BIT  = 6;
	localparam int GATE_TM_BIT   = 5;
	localparam int GATE_SPM_BIT  = 4;
	localparam int GATE_GO_BIT   = 3;
	localparam int GATE_VAL_BIT  = 2;
	localparam int GATE_SS_LSB   = 0;
	// interrupt status bits
	localparam int IRQ_OVF_BIT   = 0;
	localparam int IRQ_GATE_BIT  = 1;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	// clock source and gate source codes
	localparam logic [1:0] CS_INSTR = 2'h0;
	localparam logic [1:0] CS_SYS   = 2'h1;
	localparam logic [1:0] CS_PIN   = 2'h2;
	localparam logic [1:0] CS_LFOSC = 2'h3;
	localparam logic [1:0] GS_PIN   = 2'h0;
	localparam logic [1:0] GS_OVF   = 2'h1;
	localparam logic [1:0] GS_CMP   = 2'h2;
	localparam int INSTR_DIV = 4;

	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} gtm_bus_t;

	typedef struct packed {
		logic extClkPin;
		logic lowFreqOsc;
		logic gatePin;
		logic byteTimerOvf;
		logic cmpSync;
	} gtm_src_t;
endpackage

// >>> bench/gtm_src_model.sv
// far-side source model: clock pin, lf osc, gate sources
module gtm_src_model (
	input  wire logic        clk,
	input  wire logic        gateLvl,
	input  wire logic [1:0]  which,
	output gtm_pkg::gtm_src_t src
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] cnt = 5'h0;
	always_ff @(posedge clk)
	begin
		cnt <= cnt + 5'h1;
	end
	// unselected gate sources idle low, so a wrong select shows
	// free running: pin period 8 cycles, lf osc period 32
	assign src = '{extClkPin: cnt[2], lowFreqOsc: cnt[4], gatePin: (which == 2'h0) & gateLvl,
		byteTimerOvf: (which == 2'h1) & gateLvl, cmpSync: (which == 2'h2) & gateLvl};
endmodule

// >>> bench/testbench.sv
// self-checking bench for the gated 16-bit timer control block
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [2:0] CTL = gtm_pkg::ADDR_CTRL;
	localparam logic [2:0] GAT = gtm_pkg::ADDR_GATE;
	localparam logic [2:0] CLO = gtm_pkg::ADDR_CNT_LO;
	localparam logic [2:0] CHI = gtm_pkg::ADDR_CNT_HI;
	localparam logic [2:0] IST = gtm_pkg::ADDR_IRQ_ST;
	localparam logic [2:0] IMK = gtm_pkg::ADDR_IRQ_MSK;
	logic              clk = 1'b0;
	logic              arst_n = 1'b0;
	gtm_pkg::gtm_bus_t bus = '0;
	logic [7:0]        rdata;
	gtm_pkg::gtm_src_t src;
	logic              irq;
	logic              gateLvl = 1'b0;
	logic [1:0]        which = 2'h0;
	logic [7:0]        d;
	logic [15:0]       c;
	logic [1:0]        cs;
	logic [1:0]        ps;
	int                n;
	int                fail_count = 0;
	int                compares = 0;
	int                cyc = 0;
	initial
	begin
		forever #5 clk = ~clk;
	end
	gtm_timer u_gtm_timer (.clk(clk), .arst_n(arst_n), .bus(bus), .rdata(rdata), .src(src), .irq(irq));
	gtm_src_model u_gtm_src_model (.clk(clk), .gateLvl(gateLvl), .which(which), .src(src));
	task automatic bad(input string m);
		fail_count++;
		$display("wrong value at %0t: %s", $time, m);
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
			bad($sformatf("got %h want %h", got, exp));
	endtask
	// counts tolerate two edges of start and stop skew
	task automatic near(input logic [15:0] got, input int exp);
		int dif;
		compares++;
		dif = int'(got) - exp;
		if ($isunknown(got) || dif > 2 || dif < -2)
			bad($sformatf("count %h want about %0d", got, exp));
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		bus <= '{a, v, 1'b1, 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [2:0] a);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		#1 d = rdata;
		@(posedge clk);
	endtask
	task automatic run(input logic [7:0] ctl, input logic [7:0] gc, input int cycles);
		wr(GAT, gc);
		wr(CLO, 8'h00);
		wr(CHI, 8'h00);
		wr(CTL, ctl | 8'h01);
		repeat (cycles - 1) @(posedge clk);
		wr(CTL, ctl);
		rd(CLO);
		c[7:0] = d;
		rd(CHI);
		c[15:8] = d;
	endtask
	task automatic pulse(input int w);
		gateLvl <= 1'b1;
		repeat (w) @(posedge clk);
		gateLvl <= 1'b0;
		repeat (8) @(posedge clk);
	endtask
	function automatic int expCnt(input logic [1:0] s, input logic [1:0] p, input int cycles);
		int per;
		per = (s == 2'h0) ? 4 : (s == 2'h1) ? 1 : (s == 2'h2) ? 8 : 32;
		return cycles / (per << p);
	endfunction
	task automatic conclude();
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// ceiling well above the roughly 15k cycles the tests need
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			bad("timeout");
			conclude();
		end
	end
	initial
	begin
		void'($urandom(32'hcc4a));
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		for (int a = 0; a < 7; a++)
		begin
			rd(3'(a));
			chk(d & 8'hfb, 8'h00);
		end
		wr(CTL, 8'hff);
		rd(CTL);
		chk(d, 8'hf5);
		wr(CTL, 8'h00);
		$display("test reset and fields done");
		for (int k = 0; k < 16; k++)
		begin
			cs = 2'(k >> 2);
			ps = 2'(k);
			n = 768 + int'($urandom % 256);
			run({cs, ps, 1'b0, 1'($urandom), 2'b00}, 8'h00, n);
			near(c, expCnt(cs, ps, n));
		end
		$display("test clock and prescale done");
		run(8'h40, 8'hc0, 100);
		near(c, 0);
		run(8'h40, 8'h80, 100);
		near(c, 100);
		gateLvl <= 1'b1;
		for (int s = 0; s < 4; s++)
		begin
			which <= 2'(s % 3);
			run(8'h40, 8'hc0 | 8'(s), 100);
			near(c, s == 3 ? 0 : 100);
		end
		$display("test gate sources done");
		which <= 2'h0;
		wr(GAT, 8'h40);
		repeat (4) @(posedge clk);
		rd(GAT);
		chk(d & 8'h04, 8'h04);
		wr(IST, 8'hff);
		wr(IMK, 8'h02);
		gateLvl <= 1'b0;
		repeat (6) @(posedge clk);
		rd(IST);
		chk(d, 8'h02);
		#1 chk({7'h0, irq}, 8'h01);
		wr(IST, 8'h02);
		rd(IST);
		chk(d, 8'h00);
		$display("test gate event done");
		wr(CLO, 8'hfe);
		wr(CHI, 8'hff);
		wr(IMK, 8'h01);
		wr(CTL, 8'h41);
		repeat (5) @(posedge clk);
		wr(CTL, 8'h40);
		rd(CHI);
		chk(d, 8'h00);
		rd(IST);
		chk(d, 8'h01);
		#1 chk({7'h0, irq}, 8'h01);
		wr(IMK, 8'h00);
		@(posedge clk);
		#1 chk({7'h0, irq}, 8'h00);
		$display("test overflow done");
		wr(CLO, 8'h00);
		wr(CHI, 8'h00);
		wr(GAT, 8'hd8);
		wr(CTL, 8'h41);
		rd(GAT);
		chk(d & 8'h08, 8'h08);
		pulse(20);
		rd(GAT);
		chk(d & 8'h08, 8'h00);
		pulse(20);
		wr(CTL, 8'h40);
		rd(CLO);
		near({8'h00, d}, 20);
		$display("test single pulse done");
		wr(GAT, 8'he0);
		wr(CTL, 8'h41);
		pulse(4);
		rd(GAT);
		chk(d & 8'h04, 8'h04);
		wr(CTL, 8'h40);
		rd(GAT);
		chk(d & 8'h04, 8'h00);
		$display("test toggle done");
		arst_n <= 1'b0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		rd(CTL);
		chk(d, 8'h00);
		rd(GAT);
		chk(d & 8'hfb, 8'h00);
		$display("test second reset done");
		conclude();
	end
endmodule
